// ===== inc/timer16_pkg.sv
package timer16_pkg;

    localparam logic [1:0] RUN_STOP = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [15:0] DUTY_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam int CLK_PERIOD_NS = 25;
    // width of the capture pulse kept in mind by software: two count clocks
    localparam int CAPTURE_MIN_CLKS = 2;

    typedef enum logic [1:0] {
        MODE_FREE,
        MODE_PULSE,
        MODE_EVENT,
        MODE_CAPTURE
    } mode_t;

    typedef struct packed {
        logic [1:0] run_mode;
        mode_t mode;
        logic [1:0] edge_a;
        logic [1:0] edge_b;
        logic duty_match_invert_enable;
        logic duty_match_irq_mask;
        logic pin_is_output;
        logic output_enable;
    } ctrl_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
        logic armed;
    } edge_state_t;

endpackage : timer16_pkg

// ===== rtl/edge_detect.sv
`timescale 1ns/1ps

module edge_detect (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic pin_i,
    input wire logic enable_i,
    input wire logic [1:0] edge_sel_i,
    output logic edge_o
);

    timer16_pkg::edge_state_t st_reg;
    timer16_pkg::edge_state_t st_next;
    logic rise;
    logic fall;

    // history starts low at reset so a pin already high shows as a rise
    always_comb begin
        st_next = st_reg;
        rise = 1'b0;
        fall = 1'b0;
        st_next.sync1 = pin_i;
        st_next.sync2 = st_reg.sync1; // see RULE16
        if (enable_i) begin
            st_next.last = st_reg.sync2;
            st_next.armed = 1'b1;
            rise = st_reg.sync2 & ~st_reg.last; // see RULE1
            fall = ~st_reg.sync2 & st_reg.last;
        end else if (st_reg.armed) begin
            // after a stop the history tracks the pin, so a held high is no edge
            st_next.last = st_reg.sync2; // see RULE2
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        case (edge_sel_i)
            timer16_pkg::EDGE_FALL: edge_o = fall;
            timer16_pkg::EDGE_RISE: edge_o = rise; // see RULE16
            timer16_pkg::EDGE_BOTH: edge_o = rise | fall;
            default: edge_o = 1'b0;
        endcase
    end

endmodule : edge_detect

// ===== rtl/timer16_pulse_capture.sv
`timescale 1ns/1ps

// Operation
// RULE1 - a capture pin high after reset gives an immediate rise when a rising edge is valid.
// RULE2 - a pin still high when counting resumes after a stop gives no rise.
// RULE3 - the shared pin is either the second capture input or the timer output.
// RULE4 - software keeps the duty compare below the period compare.
// RULE5 - pulse mode period is period compare plus one, width duty compare plus one.
// RULE6 - a duty match inverts the output only while the invert enable is set.
// RULE7 - a duty match sets the request flag; the interrupt passes only when unmasked.
// RULE8 - software disables inversion and masks the interrupt before rewriting duty.
// RULE9 - software waits one count clock, re-enables inversion, clears flag, unmasks.
// RULE10 - software clears the duty match flag by writing zero.
// RULE11 - both capture pins are inputs and driven for pulse width measurement.
// RULE12 - in event counter mode the count register holds the event count.
// RULE13 - counting starts as soon as the run mode is not the stop code.
// RULE14 - the first match after start may come one count clock late.
// RULE15 - in pulse mode a period match clears the counter and inverts the output.
// RULE16 - capture inputs are synchronized and edge-detected per selected edge.
module timer16_pulse_capture (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic count_enable_i,
    input wire timer16_pkg::ctrl_t ctrl_i,
    input wire logic [15:0] period_compare_i,
    input wire logic [15:0] duty_compare_i,
    input wire logic flag_clear_i,
    input wire logic capture_input_a_i,
    input wire logic shared_port_pin_i,
    output logic [15:0] count_register_o,
    output logic [15:0] capture_a_o,
    output logic [15:0] capture_b_o,
    output logic duty_match_irq_flag_o,
    output logic duty_match_interrupt_o,
    output logic period_match_o,
    output logic shared_port_pin_o,
    output logic shared_port_pin_oe_o
);

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] cap_a;
        logic [15:0] cap_b;
        logic flag;
        logic irq;
        logic pmatch;
        logic tout;
        logic pin_o;
        logic pin_oe;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic running;
    logic edge_a;
    logic edge_b;
    logic pin_b_in;
    logic duty_hit;
    logic period_hit;

    function automatic logic [15:0] inc16(input logic [15:0] v);
        inc16 = v + timer16_pkg::COUNT_ONE;
    endfunction : inc16

    // run mode field alone starts the counter; free, pulse and capture steps are gated by the count clock enable, event steps are not
    assign running = (ctrl_i.run_mode != timer16_pkg::RUN_STOP); // see RULE13
    // the second capture input is blanked whenever the pin drives the output
    assign pin_b_in = ctrl_i.pin_is_output ? 1'b0 : shared_port_pin_i; // see RULE3

    edge_detect u_edge_a (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .pin_i(capture_input_a_i),
        .enable_i(running),
        .edge_sel_i(ctrl_i.edge_a),
        .edge_o(edge_a)
    );

    edge_detect u_edge_b (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .pin_i(pin_b_in),
        .enable_i(running),
        .edge_sel_i(ctrl_i.edge_b),
        .edge_o(edge_b)
    );

    assign duty_hit = running && count_enable_i && ctrl_i.mode == timer16_pkg::MODE_PULSE
        && st_reg.count == duty_compare_i;
    assign period_hit = running && count_enable_i && ctrl_i.mode == timer16_pkg::MODE_PULSE
        && st_reg.count == period_compare_i;

    always_comb begin
        st_next = st_reg;
        st_next.irq = 1'b0;
        st_next.pmatch = 1'b0;
        if (!running) begin
            // stopping clears the counter, so a restart begins from zero
            st_next.count = timer16_pkg::COUNT_RESET;
        end else begin
            case (ctrl_i.mode)
                timer16_pkg::MODE_PULSE: begin
                    // start is not aligned to the count clock, so the first match may lag
                    if (count_enable_i) begin // see RULE14
                        if (period_hit) begin
                            st_next.count = timer16_pkg::COUNT_RESET; // see RULE15
                            st_next.pmatch = 1'b1;
                        end else begin
                            st_next.count = inc16(st_reg.count); // see RULE5
                        end
                    end
                end
                timer16_pkg::MODE_EVENT: begin
                    if (edge_a) begin
                        st_next.count = inc16(st_reg.count); // see RULE12
                    end
                end
                default: begin
                    if (count_enable_i) begin
                        st_next.count = inc16(st_reg.count);
                    end
                end
            endcase
        end
        // output high from period restart through duty match: width duty plus one
        if (period_hit || (duty_hit && ctrl_i.duty_match_invert_enable)) begin
            st_next.tout = ~st_reg.tout; // see RULE6
        end
        // a stopped counter sits at zero, the start of the active phase, so the
        // first duty match ends the high phase; an enabled stopped output rests high
        if (!running && ctrl_i.mode == timer16_pkg::MODE_PULSE) begin
            st_next.tout = 1'b1; // see RULE5
        end
        if (running && ctrl_i.mode == timer16_pkg::MODE_CAPTURE) begin
            if (edge_a) begin
                st_next.cap_a = st_reg.count; // see RULE11
            end
            if (edge_b && !ctrl_i.pin_is_output) begin
                st_next.cap_b = st_reg.count; // see RULE11
            end
        end
        if (flag_clear_i) begin
            st_next.flag = 1'b0; // see RULE10
        end
        // a match in the clearing cycle still sets the flag
        if (duty_hit) begin
            st_next.flag = 1'b1; // see RULE7
            st_next.irq = ~ctrl_i.duty_match_irq_mask; // see RULE7
        end
        st_next.pin_oe = ctrl_i.pin_is_output & ctrl_i.output_enable; // see RULE3
        st_next.pin_o = st_next.pin_oe & st_next.tout;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count_register_o = st_reg.count;
    assign capture_a_o = st_reg.cap_a;
    assign capture_b_o = st_reg.cap_b;
    assign duty_match_irq_flag_o = st_reg.flag;
    assign duty_match_interrupt_o = st_reg.irq;
    assign period_match_o = st_reg.pmatch;
    assign shared_port_pin_o = st_reg.pin_o;
    assign shared_port_pin_oe_o = st_reg.pin_oe;

    chk_pin_exclusive: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RULE3
        shared_port_pin_oe_o |-> $past(ctrl_i.pin_is_output))
        else $error("pin driven while not selected as output");

    chk_period_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RULE15
        period_hit |=> count_register_o == 16'h0000 && period_match_o)
        else $error("counter not cleared on period match");

    chk_duty_flag_set: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RULE7
        duty_hit |=> duty_match_irq_flag_o)
        else $error("duty match did not set flag");

    chk_irq_masked: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RULE7
        duty_match_interrupt_o |-> $past(duty_hit) && !$past(ctrl_i.duty_match_irq_mask))
        else $error("interrupt without unmasked duty match");

    chk_flag_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RULE10
        flag_clear_i && !duty_hit |=> !duty_match_irq_flag_o)
        else $error("flag not cleared");

    chk_invert_gate: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RULE6
        duty_hit && !period_hit && !ctrl_i.duty_match_invert_enable |=> $stable(st_reg.tout))
        else $error("output inverted while inversion disabled");

    chk_invert_duty: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RULE6
        duty_hit && !period_hit && ctrl_i.duty_match_invert_enable
        |=> st_reg.tout != $past(st_reg.tout))
        else $error("output not inverted on duty match");

    chk_stop_holds: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RULE13
        !running |=> count_register_o == 16'h0000)
        else $error("counter moved while stopped");

    chk_count_step: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RULE5
        running && count_enable_i && ctrl_i.mode == timer16_pkg::MODE_PULSE && !period_hit
        |=> count_register_o == $past(count_register_o) + 16'h0001)
        else $error("pulse counter did not step");

endmodule : timer16_pulse_capture

// ===== dv/pin_model.sv
`timescale 1ns/1ps

module pin_model (
    input wire logic sys_clk_i,
    input wire logic pin_i,
    input wire logic oe_i,
    output logic cap_a_o,
    output logic shared_o
);
    logic lvl_b_reg;
    initial begin
        cap_a_o = 1'b1; // pulled up, so high through reset
        lvl_b_reg = 1'b0;
    end
    // the wire carries the timer output only while the device drives it
    assign shared_o = oe_i ? pin_i : lvl_b_reg;
    // three clocks each way keeps pulses above the two-clock capture minimum
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            cap_a_o <= 1'b0;
            repeat (3) @(posedge sys_clk_i);
            cap_a_o <= 1'b1;
            repeat (2) @(posedge sys_clk_i);
        end
    endtask : pulses
    // both pins carry one pulse of w clocks: a rises at its start, b falls at its end
    task automatic width_pulse(input int w);
        @(posedge sys_clk_i);
        cap_a_o <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        cap_a_o <= 1'b1;
        lvl_b_reg <= 1'b1;
        repeat (w) @(posedge sys_clk_i);
        cap_a_o <= 1'b0;
        lvl_b_reg <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
    endtask : width_pulse
endmodule : pin_model

// ===== dv/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic sys_clk_i, resetn_i, cen, fclr, pin_a, pin_b, flag_o, irq_o, pm_o, pin_o, oe_o;
    timer16_pkg::ctrl_t ctrl;
    logic [15:0] period, duty, cnt_o, cap_a, cap_b;
    int errors, checks_done, seed, cycles, ev, n, p, d, hi, lo, irqs, pms;
    int div = 1, div_cnt, w;

    timer16_pulse_capture uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .count_enable_i(cen), .ctrl_i(ctrl), .period_compare_i(period),
        .duty_compare_i(duty), .flag_clear_i(fclr), .capture_input_a_i(pin_a),
        .shared_port_pin_i(pin_b), .count_register_o(cnt_o), .capture_a_o(cap_a),
        .capture_b_o(cap_b), .duty_match_irq_flag_o(flag_o), .duty_match_interrupt_o(irq_o),
        .period_match_o(pm_o), .shared_port_pin_o(pin_o), .shared_port_pin_oe_o(oe_o));
    pin_model m (.sys_clk_i(sys_clk_i), .pin_i(pin_o), .oe_i(oe_o), .cap_a_o(pin_a),
        .shared_o(pin_b));

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    // count clock enable: one pulse every div system clocks
    always @(posedge sys_clk_i) begin
        div_cnt <= (div_cnt + 1 >= div) ? 0 : div_cnt + 1;
        cen <= (div_cnt + 1 >= div);
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one whole high phase then one whole low phase of the timer output
    task automatic measure(output int h, output int l);
        int k;
        h = 0;
        l = 0;
        k = 0;
        while (pin_o === 1'b1 && k < 300) begin
            @(negedge sys_clk_i);
            k++;
        end
        while (pin_o !== 1'b1 && k < 600) begin
            @(negedge sys_clk_i);
            k++;
        end
        while (pin_o === 1'b1 && h < 300) begin
            @(negedge sys_clk_i);
            h++;
        end
        while (pin_o === 1'b0 && l < 300) begin
            @(negedge sys_clk_i);
            l++;
        end
    endtask : measure

    task automatic window(input int len);
        irqs = 0;
        pms = 0;
        repeat (len) begin
            @(negedge sys_clk_i);
            irqs += int'(irq_o === 1'b1);
            pms += int'(pm_o === 1'b1);
        end
    endtask : window

    initial begin
        seed = 6372;
        ctrl = '0;
        ctrl.mode = timer16_pkg::MODE_EVENT;
        ctrl.edge_a = timer16_pkg::EDGE_RISE;
        ctrl.edge_b = 2'h2;
        period = timer16_pkg::PERIOD_RESET;
        duty = timer16_pkg::DUTY_RESET;
        fclr = 1'b0;
        resetn_i = 1'b0;
        repeat (8) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        ctrl.run_mode <= 2'h1;
        repeat (6) @(negedge sys_clk_i);
        check("count after reset", cnt_o, 1);
        @(posedge sys_clk_i);
        ctrl.run_mode <= timer16_pkg::RUN_STOP;
        repeat (4) @(posedge sys_clk_i);
        ctrl.run_mode <= 2'h3;
        repeat (6) @(negedge sys_clk_i);
        check("count after restart", cnt_o, 0);
        n = ($random(seed) & 7) + 1;
        m.pulses(n);
        ev = n;
        repeat (5) @(negedge sys_clk_i);
        check("event count", cnt_o, ev);
        $display("event test done");
        @(posedge sys_clk_i);
        ctrl.run_mode <= timer16_pkg::RUN_STOP;
        ctrl.mode <= timer16_pkg::MODE_PULSE;
        ctrl.pin_is_output <= 1'b1;
        ctrl.output_enable <= 1'b1;
        ctrl.duty_match_invert_enable <= 1'b1;
        p = ($random(seed) & 15) + 4;
        d = $random(seed) & 3;
        period <= p[15:0]; // duty below period
        duty <= d[15:0];
        @(posedge sys_clk_i);
        ctrl.run_mode <= 2'h2;
        measure(hi, lo);
        check("high time", hi, d + 1);
        check("period", hi + lo, p + 1);
        check("output enable", oe_o, 1);
        window(2 * (p + 1));
        check("duty irqs", irqs, 2);
        check("period matches", pms, 2);
        check("flag", flag_o, 1);
        @(posedge sys_clk_i);
        ctrl.duty_match_invert_enable <= 1'b0;
        ctrl.duty_match_irq_mask <= 1'b1;
        @(posedge sys_clk_i);
        d = $random(seed) & 3;
        duty <= d[15:0];
        measure(hi, lo);
        check("high time no invert", hi, p + 1);
        window(2 * (p + 1));
        check("masked irqs", irqs, 0);
        @(posedge sys_clk_i);
        ctrl.duty_match_invert_enable <= 1'b1;
        ctrl.run_mode <= timer16_pkg::RUN_STOP;
        @(posedge sys_clk_i);
        fclr <= 1'b1;
        @(posedge sys_clk_i);
        fclr <= 1'b0;
        ctrl.duty_match_irq_mask <= 1'b0;
        @(negedge sys_clk_i);
        check("flag cleared", flag_o, 0);
        div = 2;
        @(posedge sys_clk_i);
        ctrl.run_mode <= 2'h1;
        measure(hi, lo);
        check("new high time", hi, 2 * (d + 1));
        check("slow period", hi + lo, 2 * (p + 1));
        @(posedge sys_clk_i);
        ctrl.pin_is_output <= 1'b0;
        repeat (2) @(negedge sys_clk_i);
        check("pin released", oe_o, 0);
        $display("pulse test done");
        div = 1;
        @(posedge sys_clk_i);
        ctrl.run_mode <= timer16_pkg::RUN_STOP;
        ctrl.mode <= timer16_pkg::MODE_CAPTURE;
        ctrl.edge_b <= timer16_pkg::EDGE_FALL;
        repeat (4) @(posedge sys_clk_i);
        ctrl.run_mode <= 2'h3;
        w = ($random(seed) & 15) + 3;
        m.width_pulse(w);
        repeat (4) @(negedge sys_clk_i);
        check("pulse width", cap_b - cap_a, w[15:0]);
        $display("capture test done");
        wrap_up();
    end
endmodule : tb_top
